// *** sapc_buf.sv ***
// two-entry result buffer with valid/ready on both sides
module sapc_buf (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [sapc_pkg::RES_BITS-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [sapc_pkg::RES_BITS-1:0] out_data
);

  logic [sapc_pkg::RES_BITS-1:0] mem_reg [sapc_pkg::BUF_DEPTH];
  logic [sapc_pkg::RES_BITS-1:0] mem_next [sapc_pkg::BUF_DEPTH];
  logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0] count_reg, count_next;
  logic push, pop;

  // full and empty come straight from the occupancy count
  assign in_ready = (count_reg != 2'(sapc_pkg::BUF_DEPTH));
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    count_next = count_reg + 2'(push) - 2'(pop);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < sapc_pkg::BUF_DEPTH; i++) begin
        mem_reg[i] <= sapc_pkg::RESULT_RST;
      end
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

endmodule

// *** sapc_checker.sv ***
// concurrent checks on the converter control block ports
module sapc_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic high_byte_select,
  input wire logic [7:0] data_bus_lines_out,
  input wire logic data_bus_oe_n,
  input wire logic eoc_n,
  input wire logic eoc_oe_n,
  input wire logic [sapc_pkg::RES_BITS-1:0] dac_code,
  input wire sapc_pkg::sapc_mux_t mux_ctrl
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // host strobes as the device sees them
  sequence write_taken;
    !cs_n && wr_n && $past(!wr_n);
  endsequence
  sequence read_start;
    !cs_n && !rd_n && $past(rd_n);
  endsequence
  // three cycles of an open read with a steady byte select
  sequence open_read;
    (!data_bus_oe_n && $stable(high_byte_select)) [*3];
  endsequence

  a_cs_high_float: assert property (cs_n [*2] |-> data_bus_oe_n && eoc_oe_n)
    else $error("outputs driven while deselected");
  a_flag_float_tie: assert property (!data_bus_oe_n |-> !eoc_oe_n)
    else $error("bus driven while flag floats");
  a_read_drives_bus: assert property (read_start |=> !data_bus_oe_n)
    else $error("read start did not drive bus");
  a_read_frees_flag: assert property (read_start |=> eoc_n)
    else $error("flag not released by read");
  a_write_frees_flag: assert property (write_taken |=> eoc_n)
    else $error("flag not released by write");
  a_conv_start_held: assert property ($rose(mux_ctrl.hold_to_neg) |->
    !mux_ctrl.track_closed && dac_code == sapc_pkg::SAR_MSB)
    else $error("conversion began with track closed");
  a_high_nibble_zero: assert property (!data_bus_oe_n && $past(high_byte_select) |->
    data_bus_lines_out[7:4] == 4'h0)
    else $error("upper lines not zero in high read");
  a_result_steady: assert property (open_read |-> $stable(data_bus_lines_out))
    else $error("result changed during open read");
endmodule

bind sapc_top sapc_checker chk (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .high_byte_select(high_byte_select), .data_bus_lines_out(data_bus_lines_out),
  .data_bus_oe_n(data_bus_oe_n), .eoc_n(eoc_n), .eoc_oe_n(eoc_oe_n), .dac_code(dac_code),
  .mux_ctrl(mux_ctrl));

// *** sapc_host.sv ***
// host processor model driving the byte-wide port and the clock pin
module sapc_host (
  input wire logic core_clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic high_byte_select,
  output logic [7:0] data_bus_lines_in,
  output logic conv_clk_pin,
  input wire logic [7:0] data_bus_lines_out,
  input wire logic data_bus_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ext_clk_run = 1'b0;
  logic [2:0] pin_div = 3'h0;

  // strobes idle high so the first edge after reset sees no stale write
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    high_byte_select = 1'b0;
    data_bus_lines_in = 8'h00;
  end

  // pin clock runs free in external mode, else tied low
  always @(negedge core_clk) begin
    pin_div <= ext_clk_run ? pin_div + 3'h1 : 3'h0;
    conv_clk_pin <= ext_clk_run & pin_div[2];
  end

  task automatic set_cs(input logic v);
    @(negedge core_clk);
    cs_n = v;
  endtask

  // byte is held through the rising write strobe edge
  task automatic write_byte(input logic [7:0] b);
    @(negedge core_clk);
    cs_n = 1'b0;
    wr_n = 1'b0;
    data_bus_lines_in = b;
    @(negedge core_clk);
    wr_n = 1'b1;
    @(negedge core_clk);
    data_bus_lines_in = ~b; // released bus shows the inverse, never a stale copy
  endtask

  task automatic read_byte(input logic sel, output logic [7:0] b, output logic oe_n);
    @(negedge core_clk);
    cs_n = 1'b0;
    high_byte_select = sel;
    rd_n = 1'b0;
    // three cycles open, so the steady-result check sees a full read window
    repeat (3) @(negedge core_clk);
    b = data_bus_lines_out;
    oe_n = data_bus_oe_n;
    rd_n = 1'b1;
  endtask
endmodule

// *** sapc_pkg.sv ***
// shared constants and types for the converter control block
package sapc_pkg;

  // result format
  localparam int RES_BITS = 12;
  localparam int LO_BITS = 8;
  localparam int HI_BITS = 4;

  // sequence timing
  localparam int CONV_TICKS = 13;
  localparam int ACQ_EXT_TICKS = 3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACQ_INT_TIME_NS = 1000;
  localparam int ACQ_INT_CYCLES = (ACQ_INT_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (ACQ_INT_TIME_NS / CLK_PERIOD_NS);
  localparam int INT_CLK_DIV = 20;
  localparam int CNT_W = 8;
  localparam int BUF_DEPTH = 2;

  // control byte, most significant field first
  typedef struct packed {
    logic [1:0] pd;
    logic acq_ext;
    logic [2:0] chan;
    logic bipolar;
    logic pseudo_diff;
  } sapc_cfg_t;

  localparam logic [1:0] PD_INT_CLK = 2'h2;
  localparam logic [1:0] PD_EXT_CLK = 2'h3;
  localparam logic [7:0] CFG_RST = 8'h80;
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [11:0] SAR_MSB = 12'h800;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] PAIR_FLIP = 3'h1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACQ_INT = 5'h02,
    ST_ACQ_EXT = 5'h04,
    ST_CONV = 5'h08,
    ST_DONE = 5'h10
  } sapc_state_t;

  // analog switch controls
  typedef struct packed {
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
    logic neg_to_common;
    logic track_closed;
    logic hold_to_neg;
  } sapc_mux_t;

  localparam logic [8:0] MUX_RST = 9'h000;

endpackage

// *** sapc_top.sv ***
// control, successive approximation and byte-wide host port of the converter
//
// Functional notes
// - end-of-conversion flag goes low once a result is finished and ready.
// - with chip select low, read strobe falling edge starts driving the result.
// - internal acquisition: write rising edge latches config, starts acquire plus convert.
// - external acquisition: next write rising edge ends acquisition, starts conversion.
// - chip select high puts flag and all eight data lines in high impedance.
// - successive approximation gives a 12-bit code, read as eight plus four bits.
// - single-ended routes selected channel positive, negative to common reference.
// - pseudo-differential uses both members of a pair; only positive side sampled.
// - acquisition end opens track switch; conversion flips hold capacitor to negative.
// - high byte select high shows four MSBs on low lines, else eight LSBs.
// - each conversion lasts 13 converter clock cycles in every mode.
// - flag returns high on first read after completion or on a new config write.
// - internal acquisition lasts three clock-pin cycles, or about 1 us internally.
module sapc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic high_byte_select,
  input wire logic [7:0] data_bus_lines_in,
  output logic [7:0] data_bus_lines_out,
  output logic data_bus_oe_n,
  output logic eoc_n,
  output logic eoc_oe_n,
  input wire logic conv_clk_pin,
  input wire logic comp_in,
  output logic [sapc_pkg::RES_BITS-1:0] dac_code,
  output sapc_pkg::sapc_mux_t mux_ctrl,
  output logic bipolar_mode
);

  // strobe edge detect, shared by both strobes
  function automatic logic rise(input logic prev, input logic now);
    rise = ~prev & now;
  endfunction

  function automatic logic fall(input logic prev, input logic now);
    fall = prev & ~now;
  endfunction

  sapc_pkg::sapc_state_t state_reg, state_next;
  sapc_pkg::sapc_cfg_t cfg_reg, cfg_next;
  sapc_pkg::sapc_mux_t mux_reg, mux_next;
  logic ext_clk_mode_reg, ext_clk_mode_next;
  logic wr_prev_reg, rd_prev_reg, clk_pin_prev_reg;
  logic [sapc_pkg::CNT_W-1:0] div_reg, div_next;
  logic [sapc_pkg::CNT_W-1:0] acq_cnt_reg, acq_cnt_next;
  logic [3:0] tick_cnt_reg, tick_cnt_next;
  logic [sapc_pkg::RES_BITS-1:0] sar_reg, sar_next;
  logic [sapc_pkg::RES_BITS-1:0] latch_reg, latch_next;
  logic eoc_n_reg, eoc_n_next;
  logic [7:0] dout_reg, dout_next;
  logic dout_oe_n_reg, dout_oe_n_next;
  logic eoc_oe_n_reg, eoc_oe_n_next;
  logic wr_done, rd_start, int_tick, conv_tick;
  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  logic [sapc_pkg::RES_BITS-1:0] buf_out_data;
  logic [3:0] bit_idx;
  sapc_pkg::sapc_cfg_t wr_cfg;

  assign wr_cfg = sapc_pkg::sapc_cfg_t'(data_bus_lines_in);
  assign wr_done = ~cs_n & rise(wr_prev_reg, wr_n);
  assign rd_start = ~cs_n & fall(rd_prev_reg, rd_n);
  assign int_tick = (div_reg == sapc_pkg::CNT_W'(sapc_pkg::INT_CLK_DIV - 1));
  // the clock pin is only trusted when external clock mode is selected
  assign conv_tick = ext_clk_mode_reg ? fall(clk_pin_prev_reg, conv_clk_pin) : int_tick;
  assign bit_idx = 4'(sapc_pkg::RES_BITS) - tick_cnt_reg;

  // internal converter clock: free-running divider giving a one-cycle enable
  always_comb begin
    div_next = int_tick ? '0 : div_reg + sapc_pkg::CNT_W'(1);
  end

  // sequencer: acquisition, conversion and hand-off to the buffer
  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_reg;
    ext_clk_mode_next = ext_clk_mode_reg;
    acq_cnt_next = acq_cnt_reg;
    tick_cnt_next = tick_cnt_reg;
    sar_next = sar_reg;
    mux_next = mux_reg;
    buf_in_valid = 1'b0;
    unique case (state_reg)
      sapc_pkg::ST_IDLE, sapc_pkg::ST_DONE: begin
        if (state_reg == sapc_pkg::ST_DONE) begin
          // stall here while the buffer is full; the word is lost only if a write ends the stall
          buf_in_valid = 1'b1;
          if (buf_in_ready) begin
            state_next = sapc_pkg::ST_IDLE;
          end
        end
      end
      sapc_pkg::ST_ACQ_INT: begin
        if (ext_clk_mode_reg ? conv_tick : 1'b1) begin
          acq_cnt_next = acq_cnt_reg + sapc_pkg::CNT_W'(1);
        end
        if ((ext_clk_mode_reg && conv_tick &&
             acq_cnt_reg == sapc_pkg::CNT_W'(sapc_pkg::ACQ_EXT_TICKS - 1)) ||
            (!ext_clk_mode_reg &&
             acq_cnt_reg == sapc_pkg::CNT_W'(sapc_pkg::ACQ_INT_CYCLES - 1))) begin
          state_next = sapc_pkg::ST_CONV;
          mux_next.track_closed = 1'b0;
          tick_cnt_next = '0;
        end
      end
      sapc_pkg::ST_ACQ_EXT: begin
      end
      sapc_pkg::ST_CONV: begin
        if (conv_tick) begin
          tick_cnt_next = tick_cnt_reg + 4'h1;
          if (tick_cnt_reg == 4'h0) begin
            mux_next.hold_to_neg = 1'b1;
            sar_next = sapc_pkg::SAR_MSB;
          end else begin
            // keep the trial bit when the comparator says input is above the dac
            if (!comp_in) begin
              sar_next[bit_idx] = 1'b0;
            end
            if (bit_idx != 4'h0) begin
              sar_next[bit_idx - 4'h1] = 1'b1;
            end
          end
          if (tick_cnt_reg == 4'(sapc_pkg::CONV_TICKS - 1)) begin
            state_next = sapc_pkg::ST_DONE;
          end
        end
      end
      default: begin
        state_next = sapc_pkg::ST_IDLE;
      end
    endcase
    // a write always wins: it aborts any conversion in flight
    if (wr_done) begin
      cfg_next = wr_cfg;
      if (wr_cfg.pd == sapc_pkg::PD_INT_CLK) begin
        ext_clk_mode_next = 1'b0;
      end else if (wr_cfg.pd == sapc_pkg::PD_EXT_CLK) begin
        ext_clk_mode_next = 1'b1;
      end
      mux_next.pos_sel = wr_cfg.chan;
      mux_next.neg_to_common = ~wr_cfg.pseudo_diff;
      mux_next.neg_sel = wr_cfg.chan ^ sapc_pkg::PAIR_FLIP;
      mux_next.hold_to_neg = 1'b0;
      acq_cnt_next = '0;
      tick_cnt_next = '0;
      if (wr_cfg.acq_ext) begin
        state_next = sapc_pkg::ST_ACQ_EXT;
        mux_next.track_closed = 1'b1;
      end else if (state_reg == sapc_pkg::ST_ACQ_EXT) begin
        state_next = sapc_pkg::ST_CONV;
        mux_next.track_closed = 1'b0;
        // channel address must match the first write; keep the one in use
        mux_next.pos_sel = mux_reg.pos_sel;
        mux_next.neg_sel = mux_reg.neg_sel;
        mux_next.neg_to_common = mux_reg.neg_to_common;
      end else begin
        state_next = sapc_pkg::ST_ACQ_INT;
        mux_next.track_closed = 1'b1;
      end
    end
  end

  // output latch and end-of-conversion flag
  always_comb begin
    latch_next = latch_reg;
    eoc_n_next = eoc_n_reg;
    // no new word enters the latch while a read cycle is open
    buf_out_ready = ~(~cs_n & ~rd_n);
    if (rd_start || wr_done) begin
      eoc_n_next = 1'b1;
    end
    // setting the flag beats a release in the same cycle
    if (buf_out_valid && buf_out_ready) begin
      latch_next = buf_out_data;
      eoc_n_next = 1'b0;
    end
  end

  // pin drivers: registered so every output comes from a flop
  always_comb begin
    dout_next = high_byte_select ?
      {{(8 - sapc_pkg::HI_BITS){1'b0}}, latch_reg[sapc_pkg::RES_BITS-1:sapc_pkg::LO_BITS]} :
      latch_reg[sapc_pkg::LO_BITS-1:0];
    dout_oe_n_next = cs_n | rd_n;
    eoc_oe_n_next = cs_n;
  end

  sapc_buf u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(sar_reg),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= sapc_pkg::ST_IDLE;
      cfg_reg <= sapc_pkg::sapc_cfg_t'(sapc_pkg::CFG_RST);
      ext_clk_mode_reg <= 1'b0;
      mux_reg <= sapc_pkg::sapc_mux_t'(sapc_pkg::MUX_RST);
      wr_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
      clk_pin_prev_reg <= 1'b0;
      div_reg <= '0;
      acq_cnt_reg <= '0;
      tick_cnt_reg <= '0;
      sar_reg <= sapc_pkg::RESULT_RST;
      latch_reg <= sapc_pkg::RESULT_RST;
      eoc_n_reg <= 1'b1;
      dout_reg <= sapc_pkg::BYTE_RST;
      dout_oe_n_reg <= 1'b1;
      eoc_oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      ext_clk_mode_reg <= ext_clk_mode_next;
      mux_reg <= mux_next;
      wr_prev_reg <= wr_n;
      rd_prev_reg <= rd_n;
      clk_pin_prev_reg <= conv_clk_pin;
      div_reg <= div_next;
      acq_cnt_reg <= acq_cnt_next;
      tick_cnt_reg <= tick_cnt_next;
      sar_reg <= sar_next;
      latch_reg <= latch_next;
      eoc_n_reg <= eoc_n_next;
      dout_reg <= dout_next;
      dout_oe_n_reg <= dout_oe_n_next;
      eoc_oe_n_reg <= eoc_oe_n_next;
    end
  end

  assign data_bus_lines_out = dout_reg;
  assign data_bus_oe_n = dout_oe_n_reg;
  assign eoc_n = eoc_n_reg;
  assign eoc_oe_n = eoc_oe_n_reg;
  assign dac_code = sar_reg;
  assign mux_ctrl = mux_reg;
  assign bipolar_mode = cfg_reg.bipolar;

endmodule

// *** sapc_top_tb.sv ***
// self-checking bench for the converter control block
module sapc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PIN_DIV = 8;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic comp_in;
  logic cs_n, rd_n, wr_n, hbs, pin, data_bus_oe_n, eoc_n, eoc_oe_n, bipolar_mode;
  logic [7:0] din, dout;
  logic [11:0] dac_code;
  logic [11:0] target = 12'h000;
  sapc_pkg::sapc_mux_t mux_ctrl;
  int n_fail = 0;
  int n_checks = 0;

  always #5 core_clk = ~core_clk;
  // ideal comparator: keep a trial bit while the trial code is not above target
  always @(negedge core_clk) comp_in <= (dac_code <= target);

  sapc_top dut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .high_byte_select(hbs), .data_bus_lines_in(din), .data_bus_lines_out(dout),
    .data_bus_oe_n(data_bus_oe_n), .eoc_n(eoc_n), .eoc_oe_n(eoc_oe_n), .conv_clk_pin(pin),
    .comp_in(comp_in), .dac_code(dac_code), .mux_ctrl(mux_ctrl), .bipolar_mode(bipolar_mode));
  sapc_host host (.core_clk(core_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .high_byte_select(hbs),
    .data_bus_lines_in(din), .conv_clk_pin(pin), .data_bus_lines_out(dout), .data_bus_oe_n(data_bus_oe_n));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // bounded wait for the flag to drop, returns cycles spent
  task automatic wait_eoc(output int n);
    n = 0;
    while (eoc_n !== 1'b0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  // low byte then high nibble; upper lines must read zero
  task automatic read_result(output logic [11:0] r);
    logic [7:0] lo, hi;
    logic oe;
    host.read_byte(1'b0, lo, oe);
    chk(oe, 1'b0);
    host.read_byte(1'b1, hi, oe);
    chk(hi[7:4], 4'h0);
    r = {hi[3:0], lo};
  endtask

  task automatic t_reset();
    chk(data_bus_oe_n, 1'b1);
    chk(eoc_oe_n, 1'b1);
  endtask

  task automatic t_internal();
    int n;
    logic [11:0] r;
    target = 12'hA5C;
    host.write_byte(8'h8C); // internal clock and acquisition, channel 3
    chk(mux_ctrl.track_closed, 1'b1);
    chk(mux_ctrl.pos_sel, 3'h3);
    chk(mux_ctrl.neg_to_common, 1'b1);
    n = 0;
    while (mux_ctrl.track_closed === 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    chk(n >= sapc_pkg::ACQ_INT_CYCLES - 3 && n <= sapc_pkg::ACQ_INT_CYCLES + 3, 1'b1);
    wait_eoc(n);
    chk(eoc_n, 1'b0);
    chk(n >= (sapc_pkg::CONV_TICKS - 1) * sapc_pkg::INT_CLK_DIV, 1'b1);
    chk(n <= (sapc_pkg::CONV_TICKS + 1) * sapc_pkg::INT_CLK_DIV, 1'b1);
    read_result(r);
    chk(r, 12'hA5C);
    chk(eoc_n, 1'b1);
    read_result(r);
    chk(r, 12'hA5C);
  endtask

  task automatic t_float();
    host.set_cs(1'b1);
    repeat (2) @(negedge core_clk);
    chk({data_bus_oe_n, eoc_oe_n}, 2'h3);
    host.set_cs(1'b0);
  endtask

  // external clock with internally timed acquisition: three pin clock falls
  task automatic t_ext_clk_acq();
    int n;
    logic [11:0] r;
    target = 12'h5A3;
    host.ext_clk_run <= 1'b1;
    host.write_byte(8'hC4);
    chk(mux_ctrl.pos_sel, 3'h1);
    chk(mux_ctrl.track_closed, 1'b1);
    n = 0;
    while (mux_ctrl.track_closed === 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    chk(n >= (sapc_pkg::ACQ_EXT_TICKS - 1) * PIN_DIV, 1'b1);
    chk(n <= (sapc_pkg::ACQ_EXT_TICKS + 1) * PIN_DIV, 1'b1);
    wait_eoc(n);
    chk(eoc_n, 1'b0);
    chk(n >= (sapc_pkg::CONV_TICKS - 1) * PIN_DIV, 1'b1);
    chk(n <= (sapc_pkg::CONV_TICKS + 1) * PIN_DIV, 1'b1);
    read_result(r);
    chk(r, 12'h5A3);
  endtask

  // external clock and acquisition, pseudo-differential pair, then a new internal-clock conversion by write
  task automatic t_external();
    int n;
    logic [11:0] r;
    target = 12'h3F1;
    host.ext_clk_run <= 1'b1;
    host.write_byte(8'hEB);
    chk(mux_ctrl.pos_sel, 3'h2);
    chk(mux_ctrl.neg_sel, 3'h3);
    chk(mux_ctrl.neg_to_common, 1'b0);
    chk(bipolar_mode, 1'b1);
    repeat (40) @(negedge core_clk);
    chk(mux_ctrl.track_closed, 1'b1);
    host.write_byte(8'hCB);
    chk(mux_ctrl.track_closed, 1'b0);
    wait_eoc(n);
    chk(eoc_n, 1'b0);
    chk(n >= (sapc_pkg::CONV_TICKS - 1) * PIN_DIV && n <= (sapc_pkg::CONV_TICKS + 1) * PIN_DIV, 1'b1);
    target = 12'hFFF;
    host.write_byte(8'h8C);
    host.ext_clk_run <= 1'b0;
    chk(eoc_n, 1'b1);
    // the pair result stays readable until the new conversion completes
    read_result(r);
    chk(r, 12'h3F1);
    wait_eoc(n);
    read_result(r);
    chk(r, 12'hFFF);
  endtask

  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_internal();
    t_float();
    t_ext_clk_acq();
    t_external();
    stop_test();
  end

  // whole run needs about eleven hundred cycles
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
